// file: pkg/bsfl_pkg.sv
package bsfl_pkg;
	localparam int REG_COUNT = 32;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [4:0] PTR_FIRST_LO = 5'h1a;
	localparam logic [4:0] PTR_SECOND_LO = 5'h1c;
	localparam int SHORT_OP_CYCLES = 1;
	localparam int LONG_OP_CYCLES = 2;

	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_IO_BIT_RAISE = 5'h01,
		OP_IO_BIT_LOWER = 5'h02,
		OP_LOGIC_SHIFT_LEFT = 5'h03,
		OP_LOGIC_SHIFT_RIGHT = 5'h04,
		OP_ROTATE_LEFT_CARRY = 5'h05,
		OP_ROTATE_RIGHT_CARRY = 5'h06,
		OP_ARITH_SHIFT_RIGHT = 5'h07,
		OP_NIBBLE_SWAP = 5'h08,
		OP_STATUS_FLAG_RAISE = 5'h09,
		OP_STATUS_FLAG_LOWER = 5'h0a,
		OP_BIT_TO_TRANSFER_FLAG = 5'h0b,
		OP_TRANSFER_FLAG_TO_BIT = 5'h0c,
		OP_COPY_REGISTER = 5'h0d,
		OP_COPY_REGISTER_PAIR = 5'h0e,
		OP_LOAD_IMMEDIATE = 5'h0f,
		OP_LOAD_FIRST = 5'h10,
		OP_LOAD_FIRST_INC = 5'h11,
		OP_LOAD_FIRST_DEC = 5'h12,
		OP_LOAD_SECOND = 5'h13,
		OP_LOAD_SECOND_INC = 5'h14,
		OP_LOAD_SECOND_DEC = 5'h15
	} bsfl_op_type;

	typedef struct packed {
		bsfl_op_type op;
		logic [4:0] dst;
		logic [4:0] src;
		logic [2:0] bit_sel;
		logic [7:0] imm;
		logic [5:0] io_addr;
	} bsfl_cmd_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} bsfl_state_type;
endpackage : bsfl_pkg

// file: core/bsfl_datapath.sv
`timescale 1ns/1ns
`default_nettype none
module bsfl_datapath #(
	parameter int MEM_ADDR_W = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire bsfl_pkg::bsfl_cmd_type cmd,
	output logic cmd_ready,
	output logic op_done,
	output logic [7:0] status_register,
	output logic [5:0] io_addr,
	output logic io_rd_en,
	input wire logic [7:0] io_rdata,
	output logic io_wr_en,
	output logic [7:0] io_wdata,
	output logic [MEM_ADDR_W-1:0] mem_addr,
	output logic mem_rd_en,
	input wire logic [7:0] mem_rdata,
	input wire logic [4:0] rf_peek_idx,
	output logic [7:0] rf_peek_data
);
	import bsfl_pkg::*;

	if (MEM_ADDR_W < 1 || MEM_ADDR_W > 16) begin : g_bad_width
		$error("MEM_ADDR_W must lie in 1..16");
	end

	logic [7:0] rf_reg [REG_COUNT];
	logic [7:0] status_reg, status_next;
	bsfl_state_type state_reg, state_next;
	bsfl_cmd_type cmd_reg;
	logic done_reg;
	logic [5:0] io_addr_reg;
	logic io_rd_reg, io_wr_reg;
	logic [7:0] io_wdata_reg;
	logic [MEM_ADDR_W-1:0] mem_addr_reg;
	logic mem_rd_reg;

	// ----------------------------------------
	// Operand decode
	// ----------------------------------------
	wire logic take = cmd_valid && (state_reg == ST_IDLE);
	wire logic [7:0] d_val = rf_reg[cmd.dst];
	wire logic [7:0] r_val = rf_reg[cmd.src];
	wire logic [7:0] bit_mask = 8'h01 << cmd.bit_sel;
	wire logic carry_in = status_reg[FLAG_C];
	wire logic is_io = (cmd.op == OP_IO_BIT_RAISE) || (cmd.op == OP_IO_BIT_LOWER);
	wire logic is_load = (cmd.op >= OP_LOAD_FIRST) && (cmd.op <= OP_LOAD_SECOND_DEC);
	wire logic is_second = (cmd.op >= OP_LOAD_SECOND);
	wire logic ptr_inc = (cmd.op == OP_LOAD_FIRST_INC) || (cmd.op == OP_LOAD_SECOND_INC);
	wire logic ptr_dec = (cmd.op == OP_LOAD_FIRST_DEC) || (cmd.op == OP_LOAD_SECOND_DEC);
	wire logic [4:0] ptr_lo = is_second ? PTR_SECOND_LO : PTR_FIRST_LO;
	wire logic [4:0] ptr_hi = ptr_lo + 5'h01;
	wire logic [15:0] ptr_val = {rf_reg[ptr_hi], rf_reg[ptr_lo]};
	wire logic [15:0] ptr_new = ptr_inc ? ptr_val + 16'h0001 :
		ptr_dec ? ptr_val - 16'h0001 : ptr_val;
	// Pre-decrement reads at the lowered pointer, post-increment at the old one
	wire logic [15:0] load_addr = ptr_dec ? ptr_new : ptr_val;
	wire logic [4:0] pair_dst = {cmd.dst[4:1], 1'b0};
	wire logic [4:0] pair_src = {cmd.src[4:1], 1'b0};

	// ----------------------------------------
	// Result and flag logic
	// ----------------------------------------
	logic [7:0] res;
	logic cout, shift_op, keep_c;
	logic wa_en, wb_en;
	logic [4:0] wa_idx, wb_idx;
	logic [7:0] wa_data, wb_data;

	always_comb begin
		res = d_val;
		cout = carry_in;
		shift_op = 1'b0;
		keep_c = 1'b0;
		case (cmd.op)
			OP_LOGIC_SHIFT_LEFT: begin
				res = {d_val[6:0], 1'b0};
				cout = d_val[7];
				shift_op = 1'b1;
			end
			OP_LOGIC_SHIFT_RIGHT: begin
				res = {1'b0, d_val[7:1]};
				cout = d_val[0];
				shift_op = 1'b1;
			end
			OP_ROTATE_LEFT_CARRY: begin
				res = {d_val[6:0], carry_in};
				cout = d_val[7];
				shift_op = 1'b1;
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res = {carry_in, d_val[7:1]};
				cout = d_val[0];
				shift_op = 1'b1;
			end
			OP_ARITH_SHIFT_RIGHT: begin
				res = {d_val[7], d_val[7:1]};
				cout = d_val[0];
				shift_op = 1'b1;
			end
			OP_NIBBLE_SWAP: res = {d_val[3:0], d_val[7:4]};
			OP_TRANSFER_FLAG_TO_BIT: begin
				res = status_reg[FLAG_T] ? (d_val | bit_mask) : (d_val & ~bit_mask);
			end
			OP_COPY_REGISTER: res = r_val;
			OP_LOAD_IMMEDIATE: res = cmd.imm;
			default: keep_c = 1'b1;
		endcase
	end

	always_comb begin
		status_next = status_reg;
		if (take && shift_op) begin
			status_next[FLAG_C] = cout;
			status_next[FLAG_N] = res[7];
			status_next[FLAG_V] = res[7] ^ cout;
			status_next[FLAG_S] = cout;
			status_next[FLAG_Z] = (res == 8'h00);
			if (cmd.op == OP_LOGIC_SHIFT_LEFT || cmd.op == OP_ROTATE_LEFT_CARRY) begin
				status_next[FLAG_H] = d_val[3];
			end
		end else if (take && cmd.op == OP_STATUS_FLAG_RAISE) begin
			status_next[cmd.bit_sel] = 1'b1;
		end else if (take && cmd.op == OP_STATUS_FLAG_LOWER) begin
			status_next[cmd.bit_sel] = 1'b0;
		end else if (take && cmd.op == OP_BIT_TO_TRANSFER_FLAG) begin
			status_next[FLAG_T] = |(r_val & bit_mask);
		end
	end

	// Two write ports: pointer pairs and register pairs need both in one edge
	always_comb begin
		wa_en = 1'b0;
		wb_en = 1'b0;
		wa_idx = cmd.dst;
		wb_idx = cmd.dst;
		wa_data = res;
		wb_data = res;
		if (state_reg == ST_EXEC) begin
			wa_en = (cmd_reg.op >= OP_LOAD_FIRST);
			wa_idx = cmd_reg.dst;
			wa_data = mem_rdata;
		end else if (take && is_load) begin
			wa_en = ptr_inc || ptr_dec;
			wb_en = ptr_inc || ptr_dec;
			wa_idx = ptr_lo;
			wb_idx = ptr_hi;
			wa_data = ptr_new[7:0];
			wb_data = ptr_new[15:8];
		end else if (take && cmd.op == OP_COPY_REGISTER_PAIR) begin
			wa_en = 1'b1;
			wb_en = 1'b1;
			wa_idx = pair_dst;
			wb_idx = pair_dst + 5'h01;
			wa_data = rf_reg[pair_src];
			wb_data = rf_reg[pair_src + 5'h01];
		end else if (take) begin
			wa_en = (shift_op || !keep_c) && !is_io;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (take && (is_io || is_load)) state_next = ST_EXEC;
			ST_EXEC: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < REG_COUNT; i++) rf_reg[i] <= REG_RESET;
		end else begin
			if (wa_en) rf_reg[wa_idx] <= wa_data;
			if (wb_en) rf_reg[wb_idx] <= wb_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			status_reg <= STATUS_RESET;
			cmd_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			status_reg <= status_next;
			if (take) cmd_reg <= cmd;
			done_reg <= (take && !is_io && !is_load) || (state_reg == ST_EXEC);
		end
	end

	// Read in the exec cycle, write back one cycle later: flags never move
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			io_addr_reg <= 6'h00;
			io_rd_reg <= 1'b0;
			io_wr_reg <= 1'b0;
			io_wdata_reg <= 8'h00;
		end else begin
			io_rd_reg <= take && is_io;
			io_wr_reg <= io_rd_reg;
			if (take && is_io) io_addr_reg <= cmd.io_addr;
			if (io_rd_reg) begin
				io_wdata_reg <= (cmd_reg.op == OP_IO_BIT_RAISE) ?
					(io_rdata | (8'h01 << cmd_reg.bit_sel)) :
					(io_rdata & ~(8'h01 << cmd_reg.bit_sel));
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_addr_reg <= '0;
			mem_rd_reg <= 1'b0;
		end else begin
			mem_rd_reg <= take && is_load;
			if (take && is_load) mem_addr_reg <= load_addr[MEM_ADDR_W-1:0];
		end
	end

	assign cmd_ready = (state_reg == ST_IDLE);
	assign op_done = done_reg;
	assign status_register = status_reg;
	assign io_addr = io_addr_reg;
	assign io_rd_en = io_rd_reg;
	assign io_wr_en = io_wr_reg;
	assign io_wdata = io_wdata_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_rd_en = mem_rd_reg;
	assign rf_peek_data = rf_reg[rf_peek_idx];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence io_rmw_s;
		io_rd_en ##1 (io_wr_en && op_done);
	endsequence

	wire logic take_shift = take && shift_op;
	wire logic [15:0] ptr_more = ptr_val + 16'h0001;
	wire logic [15:0] ptr_less = ptr_val - 16'h0001;

	io_raise_bit_a: assert property (take && cmd.op == OP_IO_BIT_RAISE |=>
		io_rmw_s and (1'b1 ##1 io_wdata[cmd_reg.bit_sel] && $stable(status_register)))
		else $error("io bit raise wrong");
	io_lower_bit_a: assert property (take && cmd.op == OP_IO_BIT_LOWER |=>
		io_rmw_s and (1'b1 ##1 !io_wdata[cmd_reg.bit_sel] && $stable(status_register)))
		else $error("io bit lower wrong");
	shift_left_a: assert property (take && cmd.op == OP_LOGIC_SHIFT_LEFT |=>
		status_register[FLAG_C] == $past(d_val[7]) && rf_reg[$past(cmd.dst)][0] == 1'b0
		&& op_done)
		else $error("shift left wrong");
	shift_right_a: assert property (take && cmd.op == OP_LOGIC_SHIFT_RIGHT |=>
		status_register[FLAG_C] == $past(d_val[0]) && !status_register[FLAG_N]
		&& rf_reg[$past(cmd.dst)][7] == 1'b0)
		else $error("shift right wrong");
	rot_left_a: assert property (take && cmd.op == OP_ROTATE_LEFT_CARRY |=>
		rf_reg[$past(cmd.dst)][0] == $past(carry_in) && status_register[FLAG_C] == $past(d_val[7]))
		else $error("rotate left wrong");
	rot_right_a: assert property (take && cmd.op == OP_ROTATE_RIGHT_CARRY |=>
		rf_reg[$past(cmd.dst)][7] == $past(carry_in) && status_register[FLAG_C] == $past(d_val[0]))
		else $error("rotate right wrong");
	arith_right_a: assert property (take && cmd.op == OP_ARITH_SHIFT_RIGHT |=>
		rf_reg[$past(cmd.dst)][7] == $past(d_val[7]) && status_register[FLAG_C] == $past(d_val[0]))
		else $error("arith shift wrong");
	shift_flags_a: assert property (take_shift |=>
		status_register[FLAG_Z] == (rf_reg[$past(cmd.dst)] == 8'h00)
		&& status_register[FLAG_N] == rf_reg[$past(cmd.dst)][7]
		&& status_register[FLAG_V] == (status_register[FLAG_N] ^ status_register[FLAG_C]))
		else $error("shift flags wrong");
	to_transfer_a: assert property (take && cmd.op == OP_BIT_TO_TRANSFER_FLAG |=>
		status_register[FLAG_T] == $past(r_val[cmd.bit_sel]) &&
		status_register[5:0] == $past(status_register[5:0])
		&& status_register[FLAG_I] == $past(status_register[FLAG_I]))
		else $error("bit to transfer wrong");
	from_transfer_a: assert property (take && cmd.op == OP_TRANSFER_FLAG_TO_BIT |=>
		rf_reg[$past(cmd.dst)][$past(cmd.bit_sel)] == status_register[FLAG_T]
		&& $stable(status_register))
		else $error("transfer to bit wrong");
	flag_force_a: assert property (take && cmd.op == OP_STATUS_FLAG_RAISE |=>
		status_register == ($past(status_register) | (8'h01 << $past(cmd.bit_sel))))
		else $error("flag raise wrong");
	flag_lower_a: assert property (take && cmd.op == OP_STATUS_FLAG_LOWER |=>
		status_register == ($past(status_register) & ~(8'h01 << $past(cmd.bit_sel))))
		else $error("flag lower wrong");
	load_inc_a: assert property (take && ptr_inc |=>
		!cmd_ready && mem_rd_en && mem_addr == $past(ptr_val[MEM_ADDR_W-1:0])
		&& {rf_reg[$past(ptr_hi)], rf_reg[$past(ptr_lo)]} == $past(ptr_more)
		##1 op_done && $stable(status_register))
		else $error("post-increment load wrong");
	load_dec_a: assert property (take && ptr_dec |=>
		mem_addr == $past(ptr_less[MEM_ADDR_W-1:0])
		&& {rf_reg[$past(ptr_hi)], rf_reg[$past(ptr_lo)]} == $past(ptr_less)
		##1 op_done && $stable(status_register))
		else $error("pre-decrement load wrong");
	move_keep_a: assert property (take && (cmd.op == OP_COPY_REGISTER
		|| cmd.op == OP_NIBBLE_SWAP || cmd.op == OP_LOAD_IMMEDIATE)
		|=> op_done && $stable(status_register))
		else $error("move changed flags");
	reg_copy_a: assert property (take && cmd.op == OP_COPY_REGISTER |=>
		rf_reg[$past(cmd.dst)] == $past(r_val))
		else $error("register copy wrong");
	pair_copy_a: assert property (take && cmd.op == OP_COPY_REGISTER_PAIR |=>
		rf_reg[$past(pair_dst)] == $past(rf_reg[pair_src])
		&& rf_reg[$past(pair_dst) + 5'h01] == $past(rf_reg[pair_src + 5'h01])
		&& $stable(status_register))
		else $error("pair copy wrong");
	nibble_swap_a: assert property (take && cmd.op == OP_NIBBLE_SWAP |=>
		rf_reg[$past(cmd.dst)] == {$past(d_val[3:0]), $past(d_val[7:4])})
		else $error("nibble swap wrong");
endmodule : bsfl_datapath
`default_nettype wire

// file: verif/test_bsfl_datapath.sv
`timescale 1ns/1ns
`default_nettype none
`define BSFL_CHK(nm, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
	end \
end
module test_bsfl_datapath;
	import bsfl_pkg::*;
	typedef struct packed {
		bsfl_op_type op;
		logic [4:0] dst;
		logic [4:0] src;
		logic [2:0] bs;
		logic [7:0] imm;
		logic [4:0] idx;
		logic [7:0] data;
		logic [7:0] stat;
		logic [7:0] mask;
	} bsfl_row_type;
	logic clk, resetn, cmd_valid, cmd_ready, op_done, io_rd_en, io_wr_en, mem_rd_en;
	bsfl_cmd_type cmd;
	logic [7:0] status_register, io_rdata, io_wdata, mem_rdata, rf_peek_data;
	logic [5:0] io_addr;
	logic [5:0] io_wr_addr = 6'h00;
	logic [15:0] mem_addr;
	logic [15:0] rd_addr_seen = 16'h0000;
	logic [4:0] rf_peek_idx;
	logic [7:0] io_reg = 8'h5a;
	logic [7:0] tick = 8'h00;
	logic [7:0] exp_stat;
	int n_fail, check_count, cyc;
	// ----------------------------------------
	// Far side: one I/O byte and a patterned memory
	// ----------------------------------------
	// Unselected read lines show the inverted I/O byte or a running count so a stale sample cannot pass
	assign io_rdata = io_rd_en ? io_reg : ~io_reg;
	assign mem_rdata = mem_rd_en ? (mem_addr[7:0] ^ 8'h5a) : tick;
	always @(posedge clk) begin
		tick <= tick + 8'h01;
		if (io_wr_en === 1'b1) begin
			io_reg <= io_wdata;
			io_wr_addr <= io_addr;
		end
		if (mem_rd_en === 1'b1)
			rd_addr_seen <= mem_addr;
	end
	bsfl_datapath #(.MEM_ADDR_W(16)) bsfl_datapath_i (
		.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.op_done(op_done), .status_register(status_register), .io_addr(io_addr),
		.io_rd_en(io_rd_en), .io_rdata(io_rdata), .io_wr_en(io_wr_en), .io_wdata(io_wdata),
		.mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
		.rf_peek_idx(rf_peek_idx), .rf_peek_data(rf_peek_data)
	);
	bsfl_row_type rows [16] = '{
		'{OP_LOAD_IMMEDIATE, 5'h10, 5'h00, 3'h0, 8'h81, 5'h10, 8'h81, 8'h00, 8'hff},
		'{OP_LOGIC_SHIFT_LEFT, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'h02, 8'h19, 8'hff},
		'{OP_ROTATE_LEFT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'h05, 8'h00, 8'hff},
		'{OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 3'h0, 8'h81, 5'h11, 8'h81, 8'h00, 8'hff},
		'{OP_LOGIC_SHIFT_RIGHT, 5'h11, 5'h00, 3'h0, 8'h00, 5'h11, 8'h40, 8'h19, 8'hdf},
		'{OP_ROTATE_RIGHT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'h82, 8'h15, 8'hdf},
		'{OP_ARITH_SHIFT_RIGHT, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'hc1, 8'h0c, 8'hdf},
		'{OP_LOAD_IMMEDIATE, 5'h16, 5'h00, 3'h0, 8'h80, 5'h16, 8'h80, 8'h0c, 8'hdf},
		'{OP_LOGIC_SHIFT_LEFT, 5'h16, 5'h00, 3'h0, 8'h00, 5'h16, 8'h00, 8'h1b, 8'hff},
		'{OP_NIBBLE_SWAP, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'h1c, 8'h1b, 8'hff},
		'{OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h10, 3'h2, 8'h00, 5'h10, 8'h1c, 8'h5b, 8'hff},
		'{OP_TRANSFER_FLAG_TO_BIT, 5'h11, 5'h00, 3'h0, 8'h00, 5'h11, 8'h41, 8'h5b, 8'hff},
		'{OP_COPY_REGISTER, 5'h12, 5'h10, 3'h0, 8'h00, 5'h12, 8'h1c, 8'h5b, 8'hff},
		'{OP_LOAD_IMMEDIATE, 5'h13, 5'h00, 3'h0, 8'ha5, 5'h13, 8'ha5, 8'h5b, 8'hff},
		'{OP_COPY_REGISTER_PAIR, 5'h14, 5'h12, 3'h0, 8'h00, 5'h15, 8'ha5, 8'h5b, 8'hff},
		'{OP_NONE, 5'h10, 5'h00, 3'h0, 8'h00, 5'h10, 8'h1c, 8'h5b, 8'hff}
	};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	// Returns cycles from the taking edge to the done pulse
	task automatic issue(input bsfl_cmd_type c, output int cy);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		cmd = c;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		cy = 1;
		while (op_done !== 1'b1 && cy < 8) begin
			@(posedge clk);
			#1;
			cy++;
		end
		if (op_done !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED op_done expected 1 seen %b", op_done);
			stop_test();
		end
	endtask : issue
	// Peek index moves just after an edge, like every other input
	task automatic chk_reg(input logic [4:0] idx, input logic [7:0] exp);
		@(posedge clk);
		#1;
		rf_peek_idx = idx;
		#1;
		`BSFL_CHK("rf_peek_data", exp, rf_peek_data)
	endtask : chk_reg
	task automatic load_chk(input bsfl_op_type op, input logic [4:0] lo, input logic [15:0] ptr,
			input logic [15:0] adr, input logic [15:0] nxt);
		issue('{OP_LOAD_IMMEDIATE, lo, 5'h00, 3'h0, ptr[7:0], 6'h00}, cyc);
		issue('{OP_LOAD_IMMEDIATE, lo + 5'h01, 5'h00, 3'h0, ptr[15:8], 6'h00}, cyc);
		issue('{op, 5'h05, 5'h00, 3'h0, 8'h00, 6'h00}, cyc);
		`BSFL_CHK("load cycles", 2, cyc)
		`BSFL_CHK("mem_addr", adr, rd_addr_seen)
		chk_reg(5'h05, adr[7:0] ^ 8'h5a);
		chk_reg(lo, nxt[7:0]);
		chk_reg(lo + 5'h01, nxt[15:8]);
		`BSFL_CHK("status_register", 8'hff, status_register)
	endtask : load_chk
	task automatic io_op(input bsfl_op_type op, input logic [2:0] bs, input logic [7:0] exp);
		issue('{op, 5'h00, 5'h00, bs, 8'h00, 6'h2d}, cyc);
		`BSFL_CHK("io cycles", 2, cyc)
		@(posedge clk);
		#1;
		`BSFL_CHK("io byte", exp, io_reg)
		`BSFL_CHK("io_addr", 6'h2d, io_wr_addr)
		`BSFL_CHK("status_register", 8'hff, status_register)
	endtask : io_op
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		rf_peek_idx = 5'h00;
		n_fail = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		#1;
		`BSFL_CHK("cmd_ready", 1'b1, cmd_ready)
		resetn = 1'b1;
		`BSFL_CHK("status_register", 8'h00, status_register)
		`BSFL_CHK("op_done", 1'b0, op_done)
		foreach (rows[i]) begin
			issue('{rows[i].op, rows[i].dst, rows[i].src, rows[i].bs, rows[i].imm, 6'h00}, cyc);
			`BSFL_CHK("cycles", 1, cyc)
			chk_reg(rows[i].idx, rows[i].data);
			`BSFL_CHK("status", rows[i].stat & rows[i].mask, status_register & rows[i].mask)
		end
		exp_stat = 8'h5b;
		// Each flag alone: lower all in turn, then raise all in turn
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 8; i++) begin
				issue('{k == 1 ? OP_STATUS_FLAG_RAISE : OP_STATUS_FLAG_LOWER, 5'h00, 5'h00,
					i[2:0], 8'h00, 6'h00}, cyc);
				exp_stat[i] = k[0];
				`BSFL_CHK("flag cycles", 1, cyc)
				`BSFL_CHK("status", exp_stat, status_register)
			end
		end
		load_chk(OP_LOAD_FIRST_INC, PTR_FIRST_LO, 16'h0010, 16'h0010, 16'h0011);
		load_chk(OP_LOAD_FIRST_DEC, PTR_FIRST_LO, 16'h0000, 16'hffff, 16'hffff);
		load_chk(OP_LOAD_SECOND_INC, PTR_SECOND_LO, 16'h00ff, 16'h00ff, 16'h0100);
		load_chk(OP_LOAD_SECOND_DEC, PTR_SECOND_LO, 16'h1200, 16'h11ff, 16'h11ff);
		load_chk(OP_LOAD_FIRST, PTR_FIRST_LO, 16'h0a0b, 16'h0a0b, 16'h0a0b);
		load_chk(OP_LOAD_SECOND, PTR_SECOND_LO, 16'h0305, 16'h0305, 16'h0305);
		io_op(OP_IO_BIT_RAISE, 3'h0, 8'h5b);
		io_op(OP_IO_BIT_RAISE, 3'h7, 8'hdb);
		io_op(OP_IO_BIT_LOWER, 3'h6, 8'h9b);
		io_op(OP_IO_BIT_LOWER, 3'h0, 8'h9a);
		// Reset in mid-run clears flags and registers at once
		@(posedge clk);
		#1;
		resetn = 1'b0;
		#2;
		`BSFL_CHK("status_register", 8'h00, status_register)
		`BSFL_CHK("cmd_ready", 1'b1, cmd_ready)
		chk_reg(5'h10, 8'h00);
		@(posedge clk);
		#1;
		resetn = 1'b1;
		// First command after release must see clean registers and flags
		issue('{OP_LOGIC_SHIFT_LEFT, 5'h10, 5'h00, 3'h0, 8'h00, 6'h00}, cyc);
		`BSFL_CHK("cycles", 1, cyc)
		`BSFL_CHK("status", 8'h02, status_register)
		chk_reg(5'h10, 8'h00);
		stop_test();
	end
endmodule : test_bsfl_datapath
`default_nettype wire
